// File: rtl/sfd_decoder.sv
// Purpose: Command front end of a serial flash: opcode decode, address, dummy, read stream, program data.
// Assumes: Serial clock, chip select and I/O arrive asynchronously and are oversampled by mclk.
// Notes: Double-rate reads are decoded and flagged; their inputs shift on rising edges only and their output on falling edges only.
`timescale 1ns/1ps
module sfd_decoder #(
   parameter int FIFO_W = sfd_pkg::FIFO_WIDTH,
   parameter int FIFO_D = sfd_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   // Configuration
   input wire logic dummy_cfg_low,
   input wire logic dummy_cfg_high,
   // Mode status
   output logic quad_command_mode,
   output logic wide_addr_mode,
   // Command to array
   output logic cmd_valid,
   output sfd_pkg::sfd_cmd_s cmd,
   output logic cmd_reject,
   // Read data from array
   output logic rd_req,
   output logic [31:0] rd_addr,
   input wire logic [7:0] rd_data,
   // Program data to array
   output logic prog_valid,
   output logic [7:0] prog_data,
   input wire logic prog_ready
);
   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] s3;
      logic [5:0] stab;
      sfd_pkg::sfd_state_e state;
      logic quad;
      logic wide;
      logic [7:0] sh;
      logic [3:0] cnt;
      sfd_pkg::sfd_kind_e kind;
      logic [31:0] addr;
      logic [2:0] addr_left;
      logic [4:0] dummy_left;
      logic [8:0] nbytes;
      logic overrun;
      logic [7:0] osh;
      logic [3:0] ocnt;
      logic [31:0] raddr;
      logic rreq;
      logic [3:0] io_o;
      logic [3:0] io_e;
      logic cvalid;
      sfd_pkg::sfd_cmd_s cmd;
      logic rej;
      logic push;
      logic [7:0] pdata;
   } sfd_st_s;

   sfd_st_s st_q, st_d;
   logic fifo_in_ready;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic sfd_pkg::sfd_kind_e decode(input logic [7:0] op);
      unique case (op)
         sfd_pkg::OP_READ: decode = sfd_pkg::K_READ; // R7
         sfd_pkg::OP_FAST: decode = sfd_pkg::K_FAST; // R7
         sfd_pkg::OP_DUAL_IO: decode = sfd_pkg::K_DUAL_IO; // R7
         sfd_pkg::OP_DUAL_OUT: decode = sfd_pkg::K_DUAL_OUT; // R8
         sfd_pkg::OP_QUAD_IO: decode = sfd_pkg::K_QUAD_IO; // R8
         sfd_pkg::OP_QUAD_OUT: decode = sfd_pkg::K_QUAD_OUT; // R8
         sfd_pkg::OP_DDR_FAST: decode = sfd_pkg::K_DDR_FAST; // R9
         sfd_pkg::OP_DDR_DUAL: decode = sfd_pkg::K_DDR_DUAL; // R9
         sfd_pkg::OP_DDR_QUAD: decode = sfd_pkg::K_DDR_QUAD; // R9
         sfd_pkg::OP_PROG: decode = sfd_pkg::K_PROG; // R10
         sfd_pkg::OP_QPROG: decode = sfd_pkg::K_QPROG; // R10
         sfd_pkg::OP_SECT: decode = sfd_pkg::K_SECT; // R11
         sfd_pkg::OP_BLK32: decode = sfd_pkg::K_BLK32; // R11
         sfd_pkg::OP_BLK64: decode = sfd_pkg::K_BLK64; // R11
         sfd_pkg::OP_CHIP_A, sfd_pkg::OP_CHIP_B: decode = sfd_pkg::K_CHIP; // R11
         sfd_pkg::OP_ENTER_QUAD: decode = sfd_pkg::K_ENTER_QUAD; // R1
         sfd_pkg::OP_EXIT_QUAD: decode = sfd_pkg::K_EXIT_QUAD; // R2
         sfd_pkg::OP_ENTER_WIDE: decode = sfd_pkg::K_ENTER_WIDE; // R6
         default: decode = sfd_pkg::K_NONE;
      endcase
   endfunction : decode

   // Commands legal in four-line mode
   function automatic logic quad_ok(input sfd_pkg::sfd_kind_e k);
      unique case (k)
         sfd_pkg::K_QUAD_IO, sfd_pkg::K_DDR_QUAD, sfd_pkg::K_PROG, sfd_pkg::K_SECT, sfd_pkg::K_BLK32,
         sfd_pkg::K_BLK64, sfd_pkg::K_CHIP, sfd_pkg::K_EXIT_QUAD, sfd_pkg::K_ENTER_WIDE: quad_ok = 1'b1; // R12
         default: quad_ok = 1'b0;
      endcase
   endfunction : quad_ok

   // Lines used for address and program data
   function automatic logic [3:0] in_lanes(input sfd_pkg::sfd_kind_e k, input logic quad);
      if (quad) begin
         in_lanes = 4'h4;
      end else begin
         unique case (k)
            sfd_pkg::K_DUAL_IO, sfd_pkg::K_DDR_DUAL: in_lanes = 4'h2;
            sfd_pkg::K_QUAD_IO, sfd_pkg::K_DDR_QUAD, sfd_pkg::K_QPROG: in_lanes = 4'h4;
            default: in_lanes = 4'h1;
         endcase
      end
   endfunction : in_lanes

   // Lines used for read output
   function automatic logic [3:0] out_lanes(input sfd_pkg::sfd_kind_e k, input logic quad);
      if (quad) begin
         out_lanes = 4'h4;
      end else begin
         unique case (k)
            sfd_pkg::K_DUAL_IO, sfd_pkg::K_DUAL_OUT, sfd_pkg::K_DDR_DUAL: out_lanes = 4'h2;
            sfd_pkg::K_QUAD_IO, sfd_pkg::K_QUAD_OUT, sfd_pkg::K_DDR_QUAD: out_lanes = 4'h4;
            default: out_lanes = 4'h1;
         endcase
      end
   endfunction : out_lanes

   function automatic logic [4:0] dummy_count(input sfd_pkg::sfd_kind_e k, input logic [1:0] cfg);
      dummy_count = 5'h00;
      if (k != sfd_pkg::K_READ) begin
         unique case (cfg) // R5
            2'h1: dummy_count = sfd_pkg::DUMMY_CFG1;
            2'h2: dummy_count = sfd_pkg::DUMMY_CFG2;
            2'h3: dummy_count = sfd_pkg::DUMMY_CFG3;
            default: begin
               unique case (k)
                  sfd_pkg::K_DUAL_IO: dummy_count = sfd_pkg::DUMMY_DEF_DUAL_IO;
                  sfd_pkg::K_QUAD_IO: dummy_count = sfd_pkg::DUMMY_DEF_QUAD_IO;
                  sfd_pkg::K_DDR_FAST, sfd_pkg::K_DDR_DUAL, sfd_pkg::K_DDR_QUAD: dummy_count = sfd_pkg::DUMMY_DEF_DDR;
                  default: dummy_count = sfd_pkg::DUMMY_DEF_FAST;
               endcase
            end
         endcase
      end
   endfunction : dummy_count

   function automatic logic is_read(input sfd_pkg::sfd_kind_e k);
      is_read = (k inside {sfd_pkg::K_READ, sfd_pkg::K_FAST, sfd_pkg::K_DUAL_IO, sfd_pkg::K_DUAL_OUT,
                           sfd_pkg::K_QUAD_IO, sfd_pkg::K_QUAD_OUT, sfd_pkg::K_DDR_FAST,
                           sfd_pkg::K_DDR_DUAL, sfd_pkg::K_DDR_QUAD});
   endfunction : is_read

   // Shift incoming lines into the byte, high bits first
   function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] io, input logic [3:0] n);
      unique case (n)
         4'h2: shift_in = {sh[5:0], io[1:0]};
         4'h4: shift_in = {sh[3:0], io};
         default: shift_in = {sh[6:0], io[0]};
      endcase
   endfunction : shift_in

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic [3:0] io_s;
   logic [3:0] lanes;
   logic [7:0] nsh;
   logic [3:0] ncnt;
   logic byte_done;

   always_comb begin
      st_d = st_q;
      st_d.s1 = {io_in, cs_n, sclk};
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < 6; i++) begin
         st_d.stab[i] = (st_q.s2[i] == st_q.s3[i]) ? st_q.s3[i] : st_q.stab[i];
      end
      sclk_rise = st_d.stab[0] && !st_q.stab[0];
      sclk_fall = !st_d.stab[0] && st_q.stab[0];
      cs_fall = !st_d.stab[1] && st_q.stab[1];
      cs_rise = st_d.stab[1] && !st_q.stab[1];
      io_s = st_d.stab[5:2];
      st_d.cvalid = 1'b0;
      st_d.rej = 1'b0;
      st_d.rreq = 1'b0;
      st_d.push = 1'b0;
      // Opcode lines depend on command mode, later phases on the command
      lanes = (st_q.state == sfd_pkg::S_OPC) ? (st_q.quad ? 4'h4 : 4'h1) : in_lanes(st_q.kind, st_q.quad); // R3
      nsh = shift_in(st_q.sh, io_s, lanes);
      ncnt = st_q.cnt + lanes;
      byte_done = (ncnt == 4'h8);

      if (cs_fall) begin
         st_d.state = sfd_pkg::S_OPC;
         st_d.cnt = 4'h0;
         st_d.kind = sfd_pkg::K_NONE;
         st_d.nbytes = 9'h000;
         st_d.overrun = 1'b0;
         st_d.ocnt = 4'h0;
      end else if (cs_rise) begin
         st_d.io_e = 4'h0; // R15
         // Only byte-aligned command ends execute
         if ((st_q.state == sfd_pkg::S_TAIL || st_q.state == sfd_pkg::S_PROG) && st_q.kind != sfd_pkg::K_NONE) begin
            if (st_q.cnt != 4'h0 || st_q.overrun || (st_q.state == sfd_pkg::S_PROG && st_q.nbytes == 9'h000)) begin
               st_d.rej = 1'b1; // R13
            end else begin
               st_d.cvalid = 1'b1; // R13
               st_d.cmd = '{kind: st_q.kind, addr: st_q.addr, nbytes: st_q.nbytes, ddr: 1'b0};
               if (st_q.kind == sfd_pkg::K_ENTER_QUAD) begin
                  st_d.quad = 1'b1; // R1
               end
               if (st_q.kind == sfd_pkg::K_EXIT_QUAD) begin
                  st_d.quad = 1'b0; // R2
               end
               if (st_q.kind == sfd_pkg::K_ENTER_WIDE) begin
                  st_d.wide = 1'b1; // R6
               end
            end
         end else if (st_q.state == sfd_pkg::S_ADDR || (st_q.state == sfd_pkg::S_OPC && st_q.cnt != 4'h0)) begin
            st_d.rej = 1'b1;
         end
         st_d.state = sfd_pkg::S_TAIL;
         st_d.kind = sfd_pkg::K_NONE;
      end else if (!st_q.stab[1] && sclk_rise) begin
         // Inputs latched on rising edge
         unique case (st_q.state) // R14
            sfd_pkg::S_OPC: begin
               st_d.sh = nsh;
               st_d.cnt = byte_done ? 4'h0 : ncnt;
               if (byte_done) begin
                  st_d.kind = decode(nsh);
                  st_d.addr = 32'h0000_0000;
                  st_d.addr_left = st_q.wide ? sfd_pkg::ADDR_BYTES_WIDE : sfd_pkg::ADDR_BYTES_NARROW; // R6
                  if (decode(nsh) == sfd_pkg::K_NONE || (st_q.quad && !quad_ok(decode(nsh)))) begin
                     st_d.kind = sfd_pkg::K_NONE; // R12
                     st_d.state = sfd_pkg::S_TAIL;
                     st_d.rej = 1'b1;
                  end else if (decode(nsh) inside {sfd_pkg::K_CHIP, sfd_pkg::K_ENTER_QUAD, sfd_pkg::K_EXIT_QUAD,
                                                   sfd_pkg::K_ENTER_WIDE}) begin
                     st_d.state = sfd_pkg::S_TAIL; // R11
                  end else begin
                     st_d.state = sfd_pkg::S_ADDR; // R16
                  end
               end
            end
            sfd_pkg::S_ADDR: begin
               st_d.sh = nsh;
               st_d.cnt = byte_done ? 4'h0 : ncnt;
               if (byte_done) begin
                  st_d.addr = {st_q.addr[23:0], nsh}; // R16
                  st_d.addr_left = st_q.addr_left - 3'h1;
                  if (st_q.addr_left == 3'h1) begin
                     if (is_read(st_q.kind)) begin
                        st_d.dummy_left = dummy_count(st_q.kind, {dummy_cfg_high, dummy_cfg_low}); // R5
                        st_d.state = (dummy_count(st_q.kind, {dummy_cfg_high, dummy_cfg_low}) == 5'h00) ?
                                     sfd_pkg::S_READ : sfd_pkg::S_DUMMY;
                        st_d.raddr = {st_q.addr[23:0], nsh};
                        st_d.rreq = 1'b1;
                        st_d.cvalid = 1'b1;
                        st_d.cmd = '{kind: st_q.kind, addr: {st_q.addr[23:0], nsh}, nbytes: 9'h000,
                                     ddr: st_q.kind inside {sfd_pkg::K_DDR_FAST, sfd_pkg::K_DDR_DUAL,
                                                            sfd_pkg::K_DDR_QUAD}};
                     end else if (st_q.kind inside {sfd_pkg::K_PROG, sfd_pkg::K_QPROG}) begin
                        st_d.state = sfd_pkg::S_PROG; // R10
                     end else begin
                        st_d.state = sfd_pkg::S_TAIL; // R11
                     end
                  end
               end
            end
            sfd_pkg::S_DUMMY: begin
               st_d.dummy_left = st_q.dummy_left - 5'h01; // R5
               if (st_q.dummy_left == 5'h01) begin
                  st_d.state = sfd_pkg::S_READ;
               end
            end
            sfd_pkg::S_PROG: begin
               st_d.sh = nsh;
               st_d.cnt = byte_done ? 4'h0 : ncnt;
               if (byte_done && st_q.nbytes != sfd_pkg::PAGE_BYTES) begin
                  st_d.nbytes = st_q.nbytes + 9'h001; // R10
                  st_d.push = 1'b1;
                  st_d.pdata = nsh;
                  if (!fifo_in_ready) begin
                     st_d.overrun = 1'b1;
                  end
               end
            end
            sfd_pkg::S_TAIL: begin
               st_d.cnt = (st_q.cnt == 4'h0) ? 4'h1 : st_q.cnt;
            end
            sfd_pkg::S_READ: begin
               st_d.cnt = st_q.cnt;
            end
         endcase
      end else if (!st_q.stab[1] && sclk_fall && st_q.state == sfd_pkg::S_READ) begin
         // Output bits move on falling edge, one byte after another
         st_d.io_e = (out_lanes(st_q.kind, st_q.quad) == 4'h4) ? 4'hF :
                     (out_lanes(st_q.kind, st_q.quad) == 4'h2) ? 4'h3 : 4'h2; // R14
         if (st_q.ocnt == 4'h0) begin
            st_d.osh = rd_data;
            st_d.raddr = st_q.raddr + 32'h0000_0001; // R15
            st_d.rreq = 1'b1;
         end else begin
            st_d.osh = st_q.osh << out_lanes(st_q.kind, st_q.quad);
         end
         unique case (out_lanes(st_q.kind, st_q.quad))
            4'h4: st_d.io_o = (st_q.ocnt == 4'h0) ? rd_data[7:4] : st_q.osh[3:0];
            4'h2: st_d.io_o = {2'h0, (st_q.ocnt == 4'h0) ? rd_data[7:6] : st_q.osh[5:4]};
            default: st_d.io_o = {2'h0, (st_q.ocnt == 4'h0) ? rd_data[7] : st_q.osh[6], 1'b0};
         endcase
         st_d.ocnt = ((st_q.ocnt + out_lanes(st_q.kind, st_q.quad)) == 4'h8) ? 4'h0 :
                     st_q.ocnt + out_lanes(st_q.kind, st_q.quad); // R15
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and outputs

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.s1 <= 6'h3E;
         st_q.s2 <= 6'h3E;
         st_q.s3 <= 6'h3E;
         st_q.stab <= 6'h3E;
         st_q.state <= sfd_pkg::S_TAIL;
         st_q.quad <= sfd_pkg::RST_QUAD_MODE;
         st_q.wide <= sfd_pkg::RST_WIDE_ADDR;
      end else begin
         st_q <= st_d;
      end
   end

   sfd_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_D)
   ) u_prog_fifo (
      .mclk(mclk),
      .reset_n(reset_n),
      .in_valid(st_q.push),
      .in_data(st_q.pdata),
      .in_ready(fifo_in_ready),
      .out_valid(prog_valid),
      .out_data(prog_data),
      .out_ready(prog_ready)
   );

   assign io_out = st_q.io_o;
   assign io_oe = st_q.io_e;
   assign quad_command_mode = st_q.quad;
   assign wide_addr_mode = st_q.wide;
   assign cmd_valid = st_q.cvalid;
   assign cmd = st_q.cmd;
   assign cmd_reject = st_q.rej;
   assign rd_req = st_q.rreq;
   assign rd_addr = st_q.raddr;
endmodule : sfd_decoder

// File: rtl/sfd_fifo.sv
// Purpose: Small synchronous FIFO for program data.
// Assumes: Single clock, valid/ready handshake on both sides.
// Notes: Flags are registered; ready and valid are their inverses and data is read from memory through a mux.
`timescale 1ns/1ps
module sfd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic full;
      logic empty;
   } sfd_fifo_s;
   sfd_fifo_s st_q, st_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign push = in_valid && !st_q.full;
   assign pop = out_ready && !st_q.empty;
   assign in_ready = !st_q.full;
   assign out_valid = !st_q.empty;
   assign out_data = mem[st_q.rp];

   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wp = st_q.wp + 1'b1;
      end
      if (pop) begin
         st_d.rp = st_q.rp + 1'b1;
      end
      st_d.cnt = st_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      st_d.full = (st_d.cnt == (AW+1)'(DEPTH));
      st_d.empty = (st_d.cnt == '0);
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         st_q <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
      end else begin
         st_q <= st_d;
      end
      if (push) begin
         mem[st_q.wp] <= in_data;
      end
   end
endmodule : sfd_fifo

// File: rtl/sfd_pkg.sv
// Purpose: Constants, types and opcode tables of the serial flash command decoder.
// Assumes: Host drives chip select, serial clock and four I/O lines; mclk oversamples them.
// Notes: Dummy counts per setting and the wide-address opcode are local choices.
// Operation
// [R1] Opcode 35h switches the device to four-line command entry for opcode, address and data.
// [R2] Only opcode F5h leaves four-line command entry, returning to single-line commands.
// [R3] Opcode bits are sampled on four lines in four-line mode and on one line otherwise.
// [R4] After either mode switch the host keeps chip select high for the minimum deselect time.
// [R5] Dummy cycles of fast, dual, quad and double-rate reads follow configuration bits 6 and 7.
// [R6] Addresses are three bytes by default and four bytes after the enter-wide-address command.
// [R7] Opcode 03h is a plain read, 0Bh a fast read with dummies, BBh a two-line address and data read.
// [R8] Opcode 3Bh reads out on two lines, EBh is a four-line address and data read, 6Bh reads out on four.
// [R9] Opcodes 0Dh, BDh and EDh are double-rate reads on one, two and four lines with address and dummies; the code flags them but shifts at single rate.
// [R10] Opcode 02h programs a page and 38h does so on four lines, each with 1 to 256 data bytes.
// [R11] Opcodes 20h, 52h and D8h erase sector, 32KB and 64KB block; 60h or C7h erase the chip without address.
// [R12] Four-line mode accepts only quad read, quad double-rate read, page program, erases and chip erase; the code also accepts F5h and B7h.
// [R13] Commands without data out execute only when chip select rises on a byte boundary.
// [R14] Input bits are latched on the rising serial clock and output bits shift on the falling one.
// [R15] Reads stream consecutive addresses while chip select stays low and stop when it rises.
// [R16] Address bytes follow the opcode directly, most significant byte first.
package sfd_pkg;
   // Opcodes
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST = 8'h0B;
   localparam logic [7:0] OP_DUAL_IO = 8'hBB;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
   localparam logic [7:0] OP_QUAD_IO = 8'hEB;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
   localparam logic [7:0] OP_DDR_FAST = 8'h0D;
   localparam logic [7:0] OP_DDR_DUAL = 8'hBD;
   localparam logic [7:0] OP_DDR_QUAD = 8'hED;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_QPROG = 8'h38;
   localparam logic [7:0] OP_SECT = 8'h20;
   localparam logic [7:0] OP_BLK32 = 8'h52;
   localparam logic [7:0] OP_BLK64 = 8'hD8;
   localparam logic [7:0] OP_CHIP_A = 8'h60;
   localparam logic [7:0] OP_CHIP_B = 8'hC7;
   localparam logic [7:0] OP_ENTER_QUAD = 8'h35;
   localparam logic [7:0] OP_EXIT_QUAD = 8'hF5;
   localparam logic [7:0] OP_ENTER_WIDE = 8'hB7;
   // Address and data sizes
   localparam logic [2:0] ADDR_BYTES_NARROW = 3'h3;
   localparam logic [2:0] ADDR_BYTES_WIDE = 3'h4;
   localparam logic [8:0] PAGE_BYTES = 9'h100;
   // Dummy cycles per configuration setting
   localparam logic [4:0] DUMMY_CFG1 = 5'h06;
   localparam logic [4:0] DUMMY_CFG2 = 5'h08;
   localparam logic [4:0] DUMMY_CFG3 = 5'h0A;
   localparam logic [4:0] DUMMY_DEF_FAST = 5'h08;
   localparam logic [4:0] DUMMY_DEF_DUAL_IO = 5'h04;
   localparam logic [4:0] DUMMY_DEF_QUAD_IO = 5'h06;
   localparam logic [4:0] DUMMY_DEF_DDR = 5'h06;
   // Reset values and FIFO size
   localparam logic RST_QUAD_MODE = 1'b0;
   localparam logic RST_WIDE_ADDR = 1'b0;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = 8;

   typedef enum logic [4:0] {
      K_NONE, K_READ, K_FAST, K_DUAL_IO, K_DUAL_OUT, K_QUAD_IO, K_QUAD_OUT, K_DDR_FAST, K_DDR_DUAL,
      K_DDR_QUAD, K_PROG, K_QPROG, K_SECT, K_BLK32, K_BLK64, K_CHIP, K_ENTER_QUAD, K_EXIT_QUAD, K_ENTER_WIDE
   } sfd_kind_e;

   typedef enum logic [5:0] {
      S_OPC = 6'b000001,
      S_ADDR = 6'b000010,
      S_DUMMY = 6'b000100,
      S_READ = 6'b001000,
      S_PROG = 6'b010000,
      S_TAIL = 6'b100000
   } sfd_state_e;

   // Command handed to the array side
   typedef struct packed {
      sfd_kind_e kind;
      logic [31:0] addr;
      logic [8:0] nbytes;
      logic ddr;
   } sfd_cmd_s;
endpackage : sfd_pkg

// File: sim/sfd_decoder_assertions.sv
// Purpose: Port-level checks of the command decoder.
// Assumes: Single mclk domain, synchronous active-low reset.
// Notes: Bound into every decoder instance.
`timescale 1ns/1ps
module sfd_decoder_assertions (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Pins
   input wire logic cs_n,
   input wire logic [3:0] io_oe,
   // Status and commands
   input wire logic quad_command_mode,
   input wire logic wide_addr_mode,
   input wire logic cmd_valid,
   input wire sfd_pkg::sfd_cmd_s cmd,
   input wire logic cmd_reject,
   input wire logic rd_req,
   input wire logic [31:0] rd_addr
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   quad_enter_a: assert property ($rose(quad_command_mode) |-> cmd_valid && cmd.kind == sfd_pkg::K_ENTER_QUAD)
      else $error("quad set without its command");
   quad_exit_a: assert property ($fell(quad_command_mode) |-> cmd_valid && cmd.kind == sfd_pkg::K_EXIT_QUAD)
      else $error("quad left without its command");
   wide_enter_a: assert property ($rose(wide_addr_mode) |-> cmd_valid && cmd.kind == sfd_pkg::K_ENTER_WIDE)
      else $error("wide address set without its command");
   wide_hold_a: assert property (wide_addr_mode |=> wide_addr_mode)
      else $error("wide address dropped");
   quad_subset_a: assert property (cmd_valid && $past(quad_command_mode) |-> cmd.kind inside {sfd_pkg::K_QUAD_IO,
      sfd_pkg::K_DDR_QUAD, sfd_pkg::K_PROG, sfd_pkg::K_SECT, sfd_pkg::K_BLK32, sfd_pkg::K_BLK64, sfd_pkg::K_CHIP,
      sfd_pkg::K_EXIT_QUAD, sfd_pkg::K_ENTER_WIDE, sfd_pkg::K_ENTER_QUAD}) else $error("command not allowed in quad");
   read_start_a: assert property (cmd_valid && cmd.kind == sfd_pkg::K_READ |-> ##[0:2] (rd_req && rd_addr == cmd.addr))
      else $error("read start not fetched");
   release_oe_a: assert property ($rose(cs_n) |-> ##[1:8] io_oe == 4'h0)
      else $error("outputs kept after deselect");
   excl_pulse_a: assert property (!(cmd_valid && cmd_reject))
      else $error("accept and reject together");
endmodule : sfd_decoder_assertions
bind sfd_decoder sfd_decoder_assertions u_chk (.mclk, .reset_n, .cs_n, .io_oe, .quad_command_mode, .wide_addr_mode,
   .cmd_valid, .cmd, .cmd_reject, .rd_req, .rd_addr);

// File: sim/sfd_decoder_tb.sv
// Purpose: Self-checking bench of the command decoder.
// Assumes: Host model drives pins; bench plays the array side.
// Notes: Array byte is its address low byte xor 5Ah.
`timescale 1ns/1ps
module sfd_decoder_tb;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic dummy_cfg_low = 1'b0, dummy_cfg_high = 1'b0, prog_ready = 1'b0;
   logic sclk, cs_n, quad_command_mode, wide_addr_mode, cmd_valid, cmd_reject, rd_req, prog_valid;
   logic [3:0] io_in, io_out, io_oe;
   logic [31:0] rd_addr;
   logic [7:0] rd_data = 8'h00, prog_data;
   sfd_pkg::sfd_cmd_s cmd, got;
   int fail_count = 0, total_checks = 0, nrej = 0;
   logic [7:0] ops [14] = '{8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED, 8'h20, 8'h52, 8'hD8,
      8'h60, 8'hC7};
   int al [14] = '{1, 1, 2, 1, 4, 1, 1, 2, 4, 1, 1, 1, 1, 1};
   sfd_pkg::sfd_kind_e kinds [14] = '{sfd_pkg::K_READ, sfd_pkg::K_FAST, sfd_pkg::K_DUAL_IO, sfd_pkg::K_DUAL_OUT,
      sfd_pkg::K_QUAD_IO, sfd_pkg::K_QUAD_OUT, sfd_pkg::K_DDR_FAST, sfd_pkg::K_DDR_DUAL, sfd_pkg::K_DDR_QUAD,
      sfd_pkg::K_SECT, sfd_pkg::K_BLK32, sfd_pkg::K_BLK64, sfd_pkg::K_CHIP, sfd_pkg::K_CHIP};
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (rd_req) rd_data <= rd_addr[7:0] ^ 8'h5A;
      if (cmd_valid) got <= cmd;
      if (cmd_reject) nrej <= nrej + 1;
   end
   sfd_host host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .io(io_in), .io_out(io_out), .io_oe(io_oe));
   sfd_decoder DUT (.mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
      .io_oe(io_oe), .dummy_cfg_low(dummy_cfg_low), .dummy_cfg_high(dummy_cfg_high),
      .quad_command_mode(quad_command_mode), .wide_addr_mode(wide_addr_mode), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_reject(cmd_reject), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .prog_valid(prog_valid),
      .prog_data(prog_data), .prog_ready(prog_ready));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic frame(input logic [7:0] op, input logic [31:0] a, input int na, input int ol, input int al_n);
      host.bits(32'(op), 8, ol);
      if (na > 0) host.bits(a, na, al_n);
      host.done();
   endtask : frame
   task automatic finish_test();
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   initial begin
      repeat (90000) @(posedge mclk);
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("quad_rst", 1'b0, quad_command_mode);
      for (int k = 0; k < 14; k++) begin
         frame(ops[k], 32'h00123450 + k, k < 12 ? 24 : 0, 1, al[k]);
         chk("kind", kinds[k], got.kind);
         if (k < 12) chk("addr", 32'h00123450 + k, got.addr);
         chk("ddr", k > 5 && k < 9, got.ddr);
      end
      for (int d = 0; d < 4; d++) begin
         {dummy_cfg_high, dummy_cfg_low} <= 2'(d);
         host.bits(d ? 32'h0B000010 : 32'h03000010, 32, 1);
         host.bits(32'h0, d ? 20 + 2 * d : 16, 1);
         host.done();
         chk("stream", 16'h4A4B, host.rx[15:0]);
      end
      frame(8'h20, 32'h0, 27, 1, 1);
      chk("misalign", 1, nrej);
      host.bits(32'h02000100, 32, 1);
      host.bits(32'hA55A, 16, 1);
      host.done();
      chk("prog_kind", sfd_pkg::K_PROG, got.kind);
      chk("prog_n", 2, got.nbytes);
      for (int b = 0; b < 2; b++) begin
         for (int t = 0; t < 50 && !prog_valid; t++) @(posedge mclk);
         chk("prog_data", b ? 8'h5A : 8'hA5, prog_data);
         prog_ready <= 1'b1;
         @(posedge mclk);
         prog_ready <= 1'b0;
         @(posedge mclk);
      end
      host.bits(32'h02, 8, 1);
      for (int w = 0; w < 7; w++) host.bits(32'h11223344 + w, 32, 1);
      host.done();
      chk("overrun", 2, nrej);
      prog_ready <= 1'b1;
      repeat (40) @(posedge mclk);
      prog_ready <= 1'b0;
      @(posedge mclk);
      chk("drained", 1'b0, prog_valid);
      frame(8'h35, 32'h0, 0, 1, 1);
      chk("quad_on", 1'b1, quad_command_mode);
      frame(8'h0B, 32'h0, 24, 4, 4);
      chk("quad_refuse", 3, nrej);
      frame(8'hEB, 32'h00ABCDEF, 24, 4, 4);
      chk("quad_addr", 32'h00ABCDEF, got.addr);
      frame(8'hB7, 32'h0, 0, 4, 4);
      chk("wide_on", 1'b1, wide_addr_mode);
      frame(8'h20, 32'h12345678, 32, 4, 4);
      chk("wide_addr", 32'h12345678, got.addr);
      frame(8'hF5, 32'h0, 0, 4, 4);
      chk("quad_off", 1'b0, quad_command_mode);
      frame(8'hD8, 32'h0A0B0C0D, 32, 1, 1);
      chk("single_addr", 32'h0A0B0C0D, got.addr);
      finish_test();
   end
endmodule : sfd_decoder_tb

// File: sim/sfd_host.sv
// Purpose: Host model driving the flash pins.
// Assumes: Mode 0, 165 ns serial clock.
// Notes: Idle lines toggle; a released output reads inverted.
`timescale 1ns/1ps
module sfd_host #(
   parameter int DESEL = 40
) (
   // Clock
   input wire logic mclk,
   // Serial pins
   output logic sclk,
   output logic cs_n,
   output logic [3:0] io,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe
);
   logic [31:0] rx = '0;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io = 4'h0;
   end
   // Set while clock low, sampled at rise
   task automatic bits(input logic [31:0] v, input int n, input int lines);
      logic [3:0] m;
      m = 4'((1 << lines) - 1);
      for (int i = n; i > 0; i -= lines) begin
         @(posedge mclk);
         cs_n <= 1'b0;
         io <= (4'(v >> (i - lines)) & m) | (~io & ~m);
         repeat (16) @(posedge mclk);
         sclk <= 1'b1;
         rx <= {rx[30:0], io_out[1] ~^ io_oe[1]};
         repeat (16) @(posedge mclk);
         sclk <= 1'b0;
      end
   endtask : bits
   // Raise chip select after the last bit, aligned or not, then deselect gap
   task automatic done();
      repeat (16) @(posedge mclk);
      cs_n <= 1'b1;
      io <= ~io;
      repeat (DESEL) @(posedge mclk);
   endtask : done
endmodule : sfd_host
